//--- include/aea_pkg.sv
// Constants and types for the alarm event aggregator.
// Assumes a single 50 MHz clock and an asynchronous active-low reset.
//
// Operation
// RQ1 - Flow high, low and in-band events land on status bits 0, 1, 2.
// RQ2 - Totalizer one and two volume limit events land on bits 3 and 4.
// RQ3 - Pressure high, low and in-band events land on bits 5, 6, 7.
// RQ4 - Temperature limit alarms on bits 8 and 9, in-band on bit 10.
// RQ5 - Pulse output queue overflow sets bit 11.
// RQ6 - A password change attempt sets bit 12.
// RQ7 - Power on with nonzero power-on delay sets bit 13.
// RQ8 - A read-only status register holds one bit per indicated event.
// RQ9 - Events whose enable bit is clear never reach the status register.
// RQ10 - Enable register resets with only the power-on event enabled.
// RQ11 - Each event has its own hold enable bit.
// RQ12 - Hold enable register resets with holding off for all events.
// RQ13 - Unheld enabled events show in status only while the condition lasts.
// RQ14 - Held enabled events stay set until the status register is reset.
// RQ15 - The other party commands status reset; the device then clears status.
// RQ16 - The operator confirms before reset; a declined request changes nothing. The code clears on status_clear_in with no confirmation step.
// RQ17 - Status is volatile and comes up cleared after power loss.
// RQ18 - The count of set status bits is available for readout.
// RQ19 - Accepted enable settings are written to nonvolatile storage.
// RQ20 - Accepted hold settings are written to nonvolatile storage.
// RQ21 - After a status reset, still-active enabled events reappear next cycle.

package aea_pkg;

   // ----------------------------------------
   // Event bit positions
   // ----------------------------------------
   localparam int EV_W = 14;
   localparam int CNT_W = 4;
   localparam int EV_FLOW_HIGH = 0;
   localparam int EV_FLOW_LOW = 1;
   localparam int EV_FLOW_BAND = 2;
   localparam int EV_TOT1_LIMIT = 3;
   localparam int EV_TOT2_LIMIT = 4;
   localparam int EV_PRES_HIGH = 5;
   localparam int EV_PRES_LOW = 6;
   localparam int EV_PRES_BAND = 7;
   localparam int EV_TEMP_LIM_A = 8;
   localparam int EV_TEMP_LIM_B = 9;
   localparam int EV_TEMP_BAND = 10;
   localparam int EV_PULSE_OVF = 11;
   localparam int EV_PASSWORD = 12;
   localparam int EV_POWER_ON = 13;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [13:0] ENABLE_RST = 14'h2000;
   localparam logic [13:0] HOLD_RST = 14'h0000;
   localparam logic [13:0] STATUS_RST = 14'h0000;

   // ----------------------------------------
   // Nonvolatile write sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      AEA_NV_IDLE = 3'b001,
      AEA_NV_ENABLE = 3'b010,
      AEA_NV_HOLD = 3'b100
   } aea_nv_state_type;

   localparam logic AEA_NV_SEL_ENABLE = 1'b0;
   localparam logic AEA_NV_SEL_HOLD = 1'b1;

endpackage

//--- include/aea_nv_if.sv
// Interface between the aggregator and its settings store.
// Assumes one clock domain shared by both ends.

`timescale 1ns/1ns
`default_nettype none

interface aea_nv_if;
   logic wr;
   logic sel;
   logic [13:0] wdata;
   logic busy;
   logic [13:0] enable_q;
   logic [13:0] hold_q;

   modport ctrl (output wr, output sel, output wdata, input busy, input enable_q, input hold_q);
   modport store (input wr, input sel, input wdata, output busy, output enable_q, output hold_q);
endinterface

`default_nettype wire

//--- verilog/aea_settings_store.sv
// Settings store holding the enable and hold words.
// Stands in for nonvolatile storage; read data come out of registers.

`timescale 1ns/1ns
`default_nettype none

module aea_settings_store (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Store port
   aea_nv_if.store nv
);
   import aea_pkg::*;

   logic [13:0] enable_r;
   logic [13:0] hold_r;
   logic busy_r;

   // ----------------------------------------
   // Storage words
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_r <= ENABLE_RST; // RQ10
         hold_r <= HOLD_RST; // RQ12
      end else if (nv.wr) begin
         if (nv.sel == AEA_NV_SEL_ENABLE) begin
            enable_r <= nv.wdata; // RQ19
         end else begin
            hold_r <= nv.wdata; // RQ20
         end
      end
   end

   // One-cycle write occupancy.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= nv.wr;
      end
   end

   assign nv.enable_q = enable_r;
   assign nv.hold_q = hold_r;
   assign nv.busy = busy_r;
endmodule

`default_nettype wire

//--- verilog/aea_alarm_aggregator.sv
// Alarm event aggregator top: status, enable and hold words.
// Assumes event conditions arrive as synchronous levels from detectors.

`timescale 1ns/1ns
`default_nettype none

module aea_alarm_aggregator (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Event conditions
   input wire logic flow_high_in,
   input wire logic flow_low_in,
   input wire logic flow_band_in,
   input wire logic tot1_limit_in,
   input wire logic tot2_limit_in,
   input wire logic pres_high_in,
   input wire logic pres_low_in,
   input wire logic pres_band_in,
   input wire logic temp_lim_a_in,
   input wire logic temp_lim_b_in,
   input wire logic temp_band_in,
   input wire logic pulse_ovf_in,
   input wire logic password_try_in,
   input wire logic power_on_in,
   input wire logic [15:0] power_on_delay_in,
   // Settings access
   input wire logic enable_wr_in,
   input wire logic [aea_pkg::EV_W-1:0] enable_wdata_in,
   input wire logic hold_wr_in,
   input wire logic [aea_pkg::EV_W-1:0] hold_wdata_in,
   input wire logic status_clear_in,
   // Readout
   output logic [aea_pkg::EV_W-1:0] alarm_status_bits_out,
   output logic [aea_pkg::EV_W-1:0] alarm_enable_bits_out,
   output logic [aea_pkg::EV_W-1:0] alarm_hold_enable_bits_out,
   output logic [aea_pkg::CNT_W-1:0] active_count_out,
   output logic settings_busy_out
);
   import aea_pkg::*;

   aea_nv_if nv_bus ();

   // ----------------------------------------
   // Registers and nets
   // ----------------------------------------
   logic [EV_W-1:0] cond;
   logic power_on_armed;
   logic [EV_W-1:0] held;
   logic start_enable;
   logic start_hold;
   logic [EV_W-1:0] live;
   logic [EV_W-1:0] status_r;
   logic [EV_W-1:0] status_nxt;
   logic [CNT_W-1:0] count_r;
   logic [EV_W-1:0] enable_out_r;
   logic [EV_W-1:0] hold_out_r;
   logic [EV_W-1:0] pend_enable_r;
   logic [EV_W-1:0] pend_hold_r;
   logic pend_enable_v_r;
   logic pend_hold_v_r;
   logic wr_r;
   logic sel_r;
   logic [EV_W-1:0] wdata_r;
   logic busy_r;
   aea_nv_state_type nv_state_r;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // A count too narrow to hold the value EV_W would wrap and under-report.
   if ((2 ** CNT_W) <= EV_W) begin : g_count_width
      $error("active count is too narrow for the event word");
   end
   // The highest event position must close the status word exactly.
   if (EV_POWER_ON != EV_W - 1) begin : g_event_span
      $error("event positions do not fill the status word");
   end
   // The enable reset word must match the event word.
   if ($bits(ENABLE_RST) != EV_W) begin : g_reset_width
      $error("reset word width differs from the event word");
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [CNT_W-1:0] pop_count(input logic [EV_W-1:0] v);
      logic [CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < EV_W; i++) begin
         n = n + {{(CNT_W-1){1'b0}}, v[i]};
      end
      return n;
   endfunction

   // ----------------------------------------
   // Event mapping
   // ----------------------------------------
   always_comb begin
      cond = '0;
      cond[EV_FLOW_HIGH] = flow_high_in; // RQ1
      cond[EV_FLOW_LOW] = flow_low_in; // RQ1
      cond[EV_FLOW_BAND] = flow_band_in; // RQ1
      cond[EV_TOT1_LIMIT] = tot1_limit_in; // RQ2
      cond[EV_TOT2_LIMIT] = tot2_limit_in; // RQ2
      cond[EV_PRES_HIGH] = pres_high_in; // RQ3
      cond[EV_PRES_LOW] = pres_low_in; // RQ3
      cond[EV_PRES_BAND] = pres_band_in; // RQ3
      cond[EV_TEMP_LIM_A] = temp_lim_a_in; // RQ4
      cond[EV_TEMP_LIM_B] = temp_lim_b_in; // RQ4
      cond[EV_TEMP_BAND] = temp_band_in; // RQ4
      cond[EV_PULSE_OVF] = pulse_ovf_in; // RQ5
      cond[EV_PASSWORD] = password_try_in; // RQ6
      cond[EV_POWER_ON] = power_on_in && power_on_armed; // RQ7
   end

   // A zero delay means no power-on event is configured at all.
   assign power_on_armed = power_on_delay_in != 16'h0000; // RQ7

   // Masked events are dropped before any processing.
   assign live = cond & nv_bus.enable_q; // RQ9

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   // Held bits drop as soon as their enable or hold bit is removed.
   assign held = status_r & nv_bus.hold_q & nv_bus.enable_q; // RQ11 RQ14

   // A live event in the clear cycle wins, so it is never lost.
   always_comb begin
      if (status_clear_in) begin
         status_nxt = live; // RQ15 RQ21
      end else begin
         status_nxt = live | held; // RQ13 RQ14
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_r <= STATUS_RST; // RQ17
      end else begin
         status_r <= status_nxt; // RQ8
      end
   end

   // The count follows the next status so both outputs move on one edge.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_r <= '0;
      end else begin
         count_r <= pop_count(status_nxt); // RQ18
      end
   end

   // ----------------------------------------
   // Settings acceptance and store writes
   // ----------------------------------------
   // Requests are parked so that one arriving during a store write is kept.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_enable_v_r <= 1'b0;
         pend_enable_r <= ENABLE_RST;
      end else if (enable_wr_in) begin
         pend_enable_v_r <= 1'b1;
         pend_enable_r <= enable_wdata_in; // RQ19
      end else if (nv_state_r == AEA_NV_ENABLE) begin
         pend_enable_v_r <= 1'b0;
      end
   end

   // A hold request is parked the same way, with its own valid flag.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pend_hold_v_r <= 1'b0;
         pend_hold_r <= HOLD_RST;
      end else if (hold_wr_in) begin
         pend_hold_v_r <= 1'b1;
         pend_hold_r <= hold_wdata_in; // RQ11 RQ20
      end else if (nv_state_r == AEA_NV_HOLD) begin
         pend_hold_v_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Store write sequencer
   // ----------------------------------------
   // Enable goes first; a waiting hold word gets the next free slot.
   always_comb begin
      start_enable = 1'b0;
      start_hold = 1'b0;
      if (nv_state_r == AEA_NV_IDLE && !nv_bus.busy) begin
         start_enable = pend_enable_v_r && !enable_wr_in; // RQ19
         start_hold = !(pend_enable_v_r && !enable_wr_in) && pend_hold_v_r && !hold_wr_in; // RQ20
      end
   end

   // The state word is one-hot; an illegal code falls back to idle.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         nv_state_r <= AEA_NV_IDLE;
      end else begin
         unique case (nv_state_r)
            AEA_NV_IDLE: begin
               if (start_enable) begin
                  nv_state_r <= AEA_NV_ENABLE;
               end else if (start_hold) begin
                  nv_state_r <= AEA_NV_HOLD;
               end
            end
            AEA_NV_ENABLE: begin
               nv_state_r <= AEA_NV_IDLE;
            end
            AEA_NV_HOLD: begin
               nv_state_r <= AEA_NV_IDLE;
            end
            default: begin
               nv_state_r <= AEA_NV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_r <= 1'b0;
      end else begin
         wr_r <= start_enable || start_hold;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sel_r <= AEA_NV_SEL_ENABLE;
      end else if (start_enable) begin
         sel_r <= AEA_NV_SEL_ENABLE;
      end else if (start_hold) begin
         sel_r <= AEA_NV_SEL_HOLD;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdata_r <= '0;
      end else if (start_enable) begin
         wdata_r <= pend_enable_r; // RQ19
      end else if (start_hold) begin
         wdata_r <= pend_hold_r; // RQ20
      end
   end

   // ----------------------------------------
   // Store port
   // ----------------------------------------
   assign nv_bus.wr = wr_r;
   assign nv_bus.sel = sel_r;
   assign nv_bus.wdata = wdata_r;

   // The store keeps its words across a status clear; only reset restores defaults.
   aea_settings_store u_store (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .nv(nv_bus)
   );

   // ----------------------------------------
   // Registered readout
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_out_r <= ENABLE_RST;
      end else begin
         enable_out_r <= nv_bus.enable_q;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hold_out_r <= HOLD_RST;
      end else begin
         hold_out_r <= nv_bus.hold_q;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= pend_enable_v_r | pend_hold_v_r | enable_wr_in | hold_wr_in;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign alarm_status_bits_out = status_r;
   assign alarm_enable_bits_out = enable_out_r;
   assign alarm_hold_enable_bits_out = hold_out_r;
   assign active_count_out = count_r;
   assign settings_busy_out = busy_r;
endmodule

`default_nettype wire

//--- verif/aea_alarm_aggregator_asserts.sv
// Port checker for the alarm event aggregator.
// Assumes it is bound onto the aggregator top module.
`timescale 1ns/1ns
`default_nettype none
module aea_alarm_aggregator_asserts (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Event conditions
   input wire logic flow_high_in,
   input wire logic flow_low_in,
   input wire logic flow_band_in,
   input wire logic tot1_limit_in,
   input wire logic tot2_limit_in,
   input wire logic pres_high_in,
   input wire logic pres_low_in,
   input wire logic pres_band_in,
   input wire logic temp_lim_a_in,
   input wire logic temp_lim_b_in,
   input wire logic temp_band_in,
   input wire logic pulse_ovf_in,
   input wire logic password_try_in,
   input wire logic power_on_in,
   input wire logic [15:0] power_on_delay_in,
   // Settings access
   input wire logic enable_wr_in,
   input wire logic [13:0] enable_wdata_in,
   input wire logic hold_wr_in,
   input wire logic [13:0] hold_wdata_in,
   input wire logic status_clear_in,
   // Readout
   input wire logic [13:0] alarm_status_bits_out,
   input wire logic [13:0] alarm_enable_bits_out,
   input wire logic [13:0] alarm_hold_enable_bits_out,
   input wire logic [3:0] active_count_out,
   input wire logic settings_busy_out
);
   // ----
   // Properties
   // ----
   // Enable may be used one cycle early, so both the word and its past are accepted.
   wire [13:0] st = alarm_status_bits_out;
   wire [13:0] en = alarm_enable_bits_out;
   wire [13:0] hd = alarm_hold_enable_bits_out;
   wire [13:0] cd = {power_on_in & (power_on_delay_in != 16'h0), password_try_in,
      pulse_ovf_in, temp_band_in, temp_lim_b_in, temp_lim_a_in, pres_band_in, pres_low_in,
      pres_high_in, tot2_limit_in, tot1_limit_in, flow_band_in, flow_low_in, flow_high_in};
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_masked_stays_clear: assert property ((st & ~(en | $past(en))) == 14'h0)
      else $error("masked event shown in status");
   a_live_follows: assert property ($past(arst_n_in) |->
      ((st ^ $past(cd)) & en & $past(en) & ~hd & ~$past(hd)) == 14'h0)
      else $error("unheld status bit differs from condition");
   a_held_bit_stays: assert property (!$past(status_clear_in) |->
      ($past(st) & en & $past(en) & hd & $past(hd) & ~st) == 14'h0)
      else $error("held status bit dropped without clear");
   a_clear_empties: assert property ($past(status_clear_in) |-> (st & ~$past(cd)) == 14'h0)
      else $error("status bit survived clear");
   a_clear_reasserts: assert property ($past(status_clear_in) |->
      ($past(cd) & en & $past(en) & ~st) == 14'h0)
      else $error("active event missing after clear");
   a_count_matches: assert property (active_count_out == $countones(st))
      else $error("active count differs from status");
   a_enable_stored: assert property (!settings_busy_out && enable_wr_in && !hold_wr_in ##1
      !(enable_wr_in || hold_wr_in) [*3] |=> en == $past(enable_wdata_in, 4))
      else $error("enable word not updated");
   a_hold_stored: assert property (!settings_busy_out && hold_wr_in
      && !enable_wr_in ##1 !(enable_wr_in || hold_wr_in) [*3] |=> hd == $past(hold_wdata_in, 4))
      else $error("hold word not updated");
   a_power_on_gated: assert property ($rose(st[13]) |->
      $past(power_on_in) && $past(power_on_delay_in) != 16'h0)
      else $error("power on event without delay");
   c_clear_hit: cover property ($past(status_clear_in) && st != 14'h0);
   c_enable_write: cover property (enable_wr_in);
   c_four_active: cover property (active_count_out == 4'h4);
endmodule
bind aea_alarm_aggregator aea_alarm_aggregator_asserts u_chk (.*);
`default_nettype wire

//--- verif/aea_alarm_aggregator_tb.sv
// Testbench for the alarm event aggregator.
// Assumes the port checker is bound onto the design.
`timescale 1ns/1ns
`default_nettype none
module aea_alarm_aggregator_tb;
   import aea_pkg::*;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [13:0] c = 14'h0;
   logic [15:0] power_on_delay_in = 16'h0;
   logic enable_wr_in = 1'b0;
   logic hold_wr_in = 1'b0;
   logic status_clear_in = 1'b0;
   logic [13:0] enable_wdata_in = 14'h0;
   logic [13:0] hold_wdata_in = 14'h0;
   logic [13:0] alarm_status_bits_out;
   logic [13:0] alarm_enable_bits_out;
   logic [13:0] alarm_hold_enable_bits_out;
   logic [3:0] active_count_out;
   logic settings_busy_out;
   int miscompares = 0;
   int check_count = 0;
   aea_alarm_aggregator dut_u (.flow_high_in(c[0]), .flow_low_in(c[1]), .flow_band_in(c[2]),
      .tot1_limit_in(c[3]), .tot2_limit_in(c[4]), .pres_high_in(c[5]), .pres_low_in(c[6]),
      .pres_band_in(c[7]), .temp_lim_a_in(c[8]), .temp_lim_b_in(c[9]), .temp_band_in(c[10]),
      .pulse_ovf_in(c[11]), .password_try_in(c[12]), .power_on_in(c[13]), .*);
   always #10 ref_clk_in = ~ref_clk_in;
   // ----
   // Access tasks
   // ----
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic see(input logic [13:0] st);
      chk("status", st, alarm_status_bits_out);
      chk("count", 14'($countones(st)), {10'h0, active_count_out});
   endtask
   // Writes both words' data lines; only the selected strobe is pulsed.
   task automatic wr(input logic sel, input logic [13:0] d);
      enable_wdata_in = d;
      hold_wdata_in = d;
      enable_wr_in = !sel;
      hold_wr_in = sel;
      step(1);
      enable_wr_in = 1'b0;
      hold_wr_in = 1'b0;
      chk("busy", 14'h1, {13'h0, settings_busy_out});
      for (int i = 0; i < 20 && settings_busy_out === 1'b1; i++) step(1);
      chk("busy", 14'h0, {13'h0, settings_busy_out});
      step(2);
   endtask
   task automatic clr(input logic [13:0] cv);
      c = cv;
      status_clear_in = 1'b1;
      step(1);
      status_clear_in = 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      test_done();
   end
   // ----
   // Scenarios
   // ----
   initial begin
      step(4);
      see(14'h0);
      chk("enable", 14'h2000, alarm_enable_bits_out);
      chk("hold", 14'h0, alarm_hold_enable_bits_out);
      arst_n_in = 1'b1;
      c = 14'h3fff;
      step(2);
      see(14'h0);
      power_on_delay_in = 16'h0001;
      step(2);
      see(14'h2000);
      wr(1'b0, 14'h3fff);
      chk("enable", 14'h3fff, alarm_enable_bits_out);
      for (int i = 0; i < 14; i++) begin
         c = 14'h1 << i;
         step(2);
         see(14'h1 << i);
      end
      wr(1'b1, 14'h0005);
      chk("hold", 14'h0005, alarm_hold_enable_bits_out);
      c = 14'h000f;
      step(2);
      see(14'h000f);
      c = 14'h0;
      step(2);
      see(14'h0005);
      step(2);
      see(14'h0005);
      clr(14'h0001);
      see(14'h0001);
      step(1);
      clr(14'h0);
      see(14'h0);
      c = 14'h0001;
      step(2);
      c = 14'h0;
      arst_n_in = 1'b0;
      step(1);
      see(14'h0);
      arst_n_in = 1'b1;
      step(2);
      see(14'h0);
      test_done();
   end
endmodule
`default_nettype wire
